// ---- verilog/tsc_cfg.svh ----
// Register offsets, reset values and timing figures of the timestamp counter
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
`define TSC_OFF_CTRL      12'h000
`define TSC_OFF_SEL       12'h004
`define TSC_OFF_PRE_LO    12'h008
`define TSC_OFF_PRE_HI    12'h00c
`define TSC_OFF_CNT_LO    12'h010
`define TSC_OFF_CNT_HI    12'h014
`define TSC_OFF_CAP_LO    12'h018
`define TSC_OFF_CAP_HI    12'h01c
`define TSC_OFF_STAT      12'h020
`define TSC_CTRL_RST      32'h0000_0000
`define TSC_SEL_RST       32'h0000_0000
`define TSC_BIT_RUN       0
`define TSC_BIT_RELOAD_EN 1
`define TSC_BIT_POL_HIGH  2
`define TSC_BIT_STAMP_EN  3
`define TSC_BIT_AUX1_OE   4
`define TSC_BIT_SRC_INT   5
`define TSC_BIT_HALT_PRE  6
`define TSC_STEP_NS       50
`define TSC_CLK_NS        10
`endif

// ---- verilog/tsc_pkg.sv ----
// Types shared by the timestamp counter files
package tsc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STAMP,
        ST_DATA
    } stream_state_t;
endpackage : tsc_pkg

// ---- verilog/tsc_sync.sv ----
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
`default_nettype none
module tsc_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule : tsc_sync
`default_nettype wire

// ---- verilog/tsc_tick.sv ----
// Count-step generator: internal divider or external count clock edges
`timescale 1ns/10ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_tick #(
    parameter int DIV = `TSC_STEP_NS / `TSC_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic use_int,
    input wire logic ext_clk_sync,
    output logic tick
);
    typedef struct packed {
        logic [7:0] div;
        logic ext_d;
    } tick_st_t;
    tick_st_t st_r;
    tick_st_t st_nxt;
    logic int_tick;

    assign int_tick = (st_r.div == 8'(DIV - 1));

    always_comb begin
        st_nxt = st_r;
        st_nxt.div = int_tick ? 8'h00 : st_r.div + 8'h01;
        st_nxt.ext_d = ext_clk_sync;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Internal source gives one step per 50 ns
    assign tick = use_int ? int_tick : (ext_clk_sync & ~st_r.ext_d);
endmodule : tsc_tick
`default_nettype wire

// ---- verilog/tsc_top.sv ----
// Timestamp counter with reload, capture and stream insertion, AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "tsc_cfg.svh"
// ============================================================
module tsc_top
    import tsc_pkg::*;
#(
    parameter int CW = 48,
    parameter int NADC = 16,
    parameter int DW = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic aux1_in,
    output logic aux1_out,
    output logic aux1_oe,
    input wire logic ext_count_clk,
    input wire logic [NADC-1:0] adc_busy,
    input wire logic adc_valid,
    input wire logic [DW-1:0] adc_data,
    output logic adc_ready,
    output logic out_valid,
    output logic [DW-1:0] out_data,
    output logic out_stamp,
    input wire logic out_ready
);
    // ============================================================
    // State
    typedef struct packed {
        logic [31:0] ctrl;
        logic [NADC-1:0] sel;
        logic [CW-1:0] preset;
        logic [CW-1:0] cnt;
        logic [CW-1:0] cap;
        logic cap_new;
        logic [NADC-1:0] busy_d;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        stream_state_t sst;
        logic [1:0] sidx;
        logic [DW-1:0] sword;
        logic [DW-1:0] odata;
        logic ovalid;
        logic ostamp;
        logic [CW-1:0] scap;
    } top_st_t;

    top_st_t st_r;
    top_st_t st_nxt;

    logic aux1_sync;
    logic ext_sync;
    logic [NADC-1:0] busy_sync;
    logic tick;
    logic reload_act;
    logic cap_evt;
    logic [CW-1:0] eff_preset;
    logic at_preset;
    logic addr_ok;
    logic [31:0] rd_mux;

    localparam int NSTAMP = (CW + DW - 1) / DW;

    // ============================================================
    // Input synchronisers
    tsc_sync #(.W(2 + NADC)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({aux1_in, ext_count_clk, adc_busy}),
        .q({aux1_sync, ext_sync, busy_sync})
    );

    tsc_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .use_int(st_r.ctrl[`TSC_BIT_SRC_INT]),
        .ext_clk_sync(ext_sync),
        .tick(tick)
    );

    // ============================================================
    // Counter control
    function automatic logic [31:0] word_of(input logic [CW-1:0] v, input logic hi);
        word_of = hi ? 32'(v >> 32) : v[31:0];
    endfunction : word_of

    // Polarity bit set: reload while high; clear: reload while low
    assign reload_act = st_r.ctrl[`TSC_BIT_RELOAD_EN]
                      & (aux1_sync == st_r.ctrl[`TSC_BIT_POL_HIGH]);
    assign cap_evt = |(busy_sync & ~st_r.busy_d & st_r.sel);
    // Zero preset stands for full range
    assign eff_preset = (st_r.preset == '0) ? {CW{1'b1}} : st_r.preset;
    assign at_preset = (st_r.cnt >= eff_preset);

    // Aux one only drives when software enables it and reload is off
    assign aux1_oe = st_r.ctrl[`TSC_BIT_AUX1_OE] & ~st_r.ctrl[`TSC_BIT_RELOAD_EN];
    assign aux1_out = st_r.ctrl[`TSC_BIT_RUN];

    // ============================================================
    // Register read mux
    // Only whole aligned words; other accesses are ignored and leave the last read data, unmapped offsets read as zero
    assign addr_ok = (haddr[1:0] == 2'b00) && (hsize == 3'b010);
    always_comb begin
        case (haddr[11:0])
            `TSC_OFF_CTRL: rd_mux = st_r.ctrl;
            `TSC_OFF_SEL: rd_mux = 32'(st_r.sel);
            `TSC_OFF_PRE_LO: rd_mux = word_of(st_r.preset, 1'b0);
            `TSC_OFF_PRE_HI: rd_mux = word_of(st_r.preset, 1'b1);
            `TSC_OFF_CNT_LO: rd_mux = word_of(st_r.cnt, 1'b0);
            `TSC_OFF_CNT_HI: rd_mux = word_of(st_r.cnt, 1'b1);
            `TSC_OFF_CAP_LO: rd_mux = word_of(st_r.cap, 1'b0);
            `TSC_OFF_CAP_HI: rd_mux = word_of(st_r.cap, 1'b1);
            `TSC_OFF_STAT: rd_mux = {29'h0, at_preset, reload_act, st_r.cap_new};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.busy_d = busy_sync;
        st_nxt.wr_pend = 1'b0;
        // Address phase
        if (hsel && hready && htrans[1] && addr_ok) begin
            st_nxt.wr_pend = hwrite;
            st_nxt.wr_addr = haddr[11:0];
            if (!hwrite) begin
                st_nxt.rdata = rd_mux;
            end
        end
        // Counting
        if (reload_act) begin
            st_nxt.cnt = '0;
        end else if (tick && st_r.ctrl[`TSC_BIT_RUN]) begin
            if (!(at_preset && st_r.ctrl[`TSC_BIT_HALT_PRE])) begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
        // Data phase write
        if (st_r.wr_pend) begin
            case (st_r.wr_addr)
                `TSC_OFF_CTRL: st_nxt.ctrl = hwdata;
                `TSC_OFF_SEL: st_nxt.sel = hwdata[NADC-1:0];
                `TSC_OFF_PRE_LO: st_nxt.preset[31:0] = hwdata;
                `TSC_OFF_PRE_HI: st_nxt.preset[CW-1:32] = hwdata[CW-33:0];
                `TSC_OFF_STAT: begin
                    if (hwdata[0]) begin
                        st_nxt.cap_new = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Capture wins over a software clear
        if (cap_evt) begin
            st_nxt.cap = st_r.cnt;
            st_nxt.cap_new = 1'b1;
        end
        // Stream: optional stamp words ahead of each ADC word
        if (st_r.ovalid && out_ready) begin
            st_nxt.ovalid = 1'b0;
        end
        case (st_r.sst)
            ST_IDLE: begin
                if (adc_valid && (!st_r.ovalid || out_ready)) begin
                    if (st_r.ctrl[`TSC_BIT_STAMP_EN]) begin
                        st_nxt.sword = adc_data;
                        st_nxt.scap = st_r.cap;
                        st_nxt.odata = DW'(st_r.cap);
                        st_nxt.ovalid = 1'b1;
                        st_nxt.ostamp = 1'b1;
                        st_nxt.sidx = 2'd1;
                        st_nxt.sst = (NSTAMP > 1) ? ST_STAMP : ST_DATA;
                    end else begin
                        st_nxt.odata = adc_data;
                        st_nxt.ovalid = 1'b1;
                        st_nxt.ostamp = 1'b0;
                    end
                end
            end
            ST_STAMP: begin
                if (out_ready) begin
                    st_nxt.odata = DW'(st_r.scap >> (DW * int'(st_r.sidx)));
                    st_nxt.ovalid = 1'b1;
                    st_nxt.sidx = st_r.sidx + 2'd1;
                    if (int'(st_r.sidx) == NSTAMP - 1) begin
                        st_nxt.sst = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (out_ready) begin
                    st_nxt.odata = st_r.sword;
                    st_nxt.ovalid = 1'b1;
                    st_nxt.ostamp = 1'b0;
                    st_nxt.sst = ST_IDLE;
                end
            end
            default: st_nxt.sst = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.ctrl <= `TSC_CTRL_RST;
            st_r.sel <= NADC'(`TSC_SEL_RST);
            st_r.sst <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign adc_ready = (st_r.sst == ST_IDLE) && (!st_r.ovalid || out_ready);
    assign out_valid = st_r.ovalid;
    assign out_data = st_r.odata;
    assign out_stamp = st_r.ostamp;

    // ============================================================
    // Checks
    AST_RELOAD_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_act |=> (st_r.cnt == '0))
        else $error("Counter not zero after reload");
    AST_POL_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.ctrl[`TSC_BIT_RELOAD_EN] && st_r.ctrl[`TSC_BIT_POL_HIGH] && aux1_sync)
        |-> reload_act)
        else $error("High aux input did not hold reload");
    AST_COUNT_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && st_r.ctrl[`TSC_BIT_RUN] && !reload_act && !st_r.ctrl[`TSC_BIT_HALT_PRE])
        |=> (st_r.cnt == $past(st_r.cnt) + 1'b1))
        else $error("Counter missed a step");
    AST_NO_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (!tick && !reload_act) |=> (st_r.cnt == $past(st_r.cnt)))
        else $error("Counter moved without a step");
    AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_evt |=> (st_r.cap == $past(st_r.cnt)) && st_r.cap_new)
        else $error("Capture did not latch counter");
    AST_CAP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !cap_evt |=> $stable(st_r.cap))
        else $error("Captured value changed without event");
    AST_PRESET_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.preset == '0) && (st_r.cnt != {CW{1'b1}}) |-> !at_preset)
        else $error("Zero preset not replaced by maximum");
    AST_AUX_OE: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.ctrl[`TSC_BIT_RELOAD_EN] |-> !aux1_oe)
        else $error("Aux one driven while used as reload");
    AST_STAMP_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
        (adc_ready && adc_valid && st_r.ctrl[`TSC_BIT_STAMP_EN])
        |=> out_valid && out_stamp && (out_data == DW'($past(st_r.cap))))
        else $error("Stamp word not placed before ADC word");
    AST_SYNC_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(adc_busy[0]) |-> ##2 busy_sync[0])
        else $error("Busy input not synchronised in time");
    AST_HALT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.ctrl[`TSC_BIT_HALT_PRE] && at_preset && !reload_act) |=> $stable(st_r.cnt))
        else $error("Counter moved past preset while halted");
    AST_STALL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (out_valid && !out_ready)
        |=> out_valid && $stable(out_data) && $stable(out_stamp))
        else $error("Stream word changed while stalled");
    AST_ADC_REFUSE: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.sst != ST_IDLE) |-> !adc_ready)
        else $error("ADC word accepted while stamp pending");
    AST_STAMP_HI: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.sst == ST_STAMP && out_ready)
        |=> out_valid && out_stamp && (out_data == DW'($past(st_r.scap) >> DW)))
        else $error("Upper stamp word wrong");

    COV_RELOAD: cover property (@(posedge hclk) disable iff (!hresetn) reload_act ##1 !reload_act);
    COV_CAPTURE: cover property (@(posedge hclk) disable iff (!hresetn) cap_evt);
    COV_STAMP: cover property (@(posedge hclk) disable iff (!hresetn)
        out_valid && out_stamp && out_ready);
    COV_PRESET: cover property (@(posedge hclk) disable iff (!hresetn) at_preset);
    COV_HALT: cover property (@(posedge hclk) disable iff (!hresetn)
        tick && st_r.ctrl[`TSC_BIT_HALT_PRE] && at_preset);
endmodule : tsc_top
`default_nettype wire

// ---- verif/tsc_far_side.sv ----
// Far-side model: reload trigger, external count clock and ADC deadtime lines
`timescale 1ns/10ps
`default_nettype none
module tsc_far_side (
    input wire logic hclk,
    output logic aux1_in,
    output logic ext_count_clk,
    output logic [15:0] adc_busy
);
    initial begin
        aux1_in = 1'b0;
        ext_count_clk = 1'b0;
        adc_busy = 16'h0000;
    end
    // Trigger level held for whole cycles, well past the two-flop stage
    task automatic trigger(input logic lvl, input int n);
        @(posedge hclk) aux1_in <= lvl;
        repeat (n) @(posedge hclk);
    endtask : trigger
    // Deadtime pulse, then idle long enough for a clean falling edge
    task automatic deadtime(input logic [15:0] m);
        @(posedge hclk) adc_busy <= m;
        repeat (6) @(posedge hclk);
        adc_busy <= 16'h0000;
        repeat (6) @(posedge hclk);
    endtask : deadtime
    // Count clock runs only while steps are asked for
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge hclk) ext_count_clk <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_count_clk <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask : steps
endmodule : tsc_far_side
`default_nettype wire

// ---- verif/timestamp_counter_reload_capture_tb.sv ----
// Self-checking bench for the timestamp counter
`timescale 1ns/10ps
`default_nettype none
`include "tsc_cfg.svh"
module timestamp_counter_reload_capture_tb;
    localparam logic [31:0] RUN = 32'h0000_0001 << `TSC_BIT_RUN;
    localparam logic [31:0] RLD = 32'h0000_0001 << `TSC_BIT_RELOAD_EN;
    localparam logic [31:0] POLH = 32'h0000_0001 << `TSC_BIT_POL_HIGH;
    localparam logic [31:0] STMP = 32'h0000_0001 << `TSC_BIT_STAMP_EN;
    localparam logic [31:0] OE = 32'h0000_0001 << `TSC_BIT_AUX1_OE;
    localparam logic [31:0] SRC = 32'h0000_0001 << `TSC_BIT_SRC_INT;
    localparam logic [31:0] HLT = 32'h0000_0001 << `TSC_BIT_HALT_PRE;
    logic hclk, hresetn, hsel, hwrite, aux1_in, ext_count_clk, adc_valid, out_ready;
    logic [31:0] haddr, hwdata, adc_data, hrdata, out_data, rd, a, b, c, ch;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] adc_busy;
    logic hreadyout, hresp, aux1_out, aux1_oe, adc_ready, out_valid, out_stamp;
    wire hready;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    assign hready = hreadyout;
    tsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux1_in(aux1_in),
        .aux1_out(aux1_out), .aux1_oe(aux1_oe), .ext_count_clk(ext_count_clk),
        .adc_busy(adc_busy), .adc_valid(adc_valid), .adc_data(adc_data),
        .adc_ready(adc_ready), .out_valid(out_valid), .out_data(out_data),
        .out_stamp(out_stamp), .out_ready(out_ready));
    tsc_far_side far (.hclk(hclk), .aux1_in(aux1_in), .ext_count_clk(ext_count_clk),
        .adc_busy(adc_busy));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // A hang anywhere ends up here; all tests need well under 3000 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end
    // ====================================
    // Shared checks and bus cycles
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string w);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h exp %h", $time, w, g, e);
        end
    endtask : check
    task automatic span(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi,
                        input string w);
        n_checks++;
        if (!((v >= lo) === 1'b1 && (v <= hi) === 1'b1)) begin
            fail_count++;
            $display("[ERR] %0t %s: %h not in %h..%h", $time, w, v, lo, hi);
        end
    endtask : span
    task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0_0000, off};
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        bus(1'b1, off, d);
    endtask : wr
    task automatic rdc(input logic [11:0] off, input logic [31:0] e, input string w);
        bus(1'b0, off, 32'h0000_0000);
        check(rd, e, w);
    endtask : rdc
    // Takes one stream word with out_ready held high
    task automatic take(input logic [31:0] e, input logic s);
        out_ready <= 1'b1;
        do @(posedge hclk); while (out_valid !== 1'b1);
        check(out_data, e, "stream word");
        check({31'h0, out_stamp}, {31'h0, s}, "stamp flag");
    endtask : take
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // ====================================
    // Scenarios
    task automatic t_reset();
        rdc(`TSC_OFF_CTRL, `TSC_CTRL_RST, "ctrl reset");
        rdc(`TSC_OFF_SEL, `TSC_SEL_RST, "select reset");
        rdc(`TSC_OFF_CNT_LO, 32'h0000_0000, "count idle");
        wr(12'h040, 32'hffff_ffff);
        rdc(12'h040, 32'h0000_0000, "unmapped read");
        rdc(`TSC_OFF_CTRL, 32'h0000_0000, "no alias write");
        check({31'h0, hresp}, 32'h0000_0000, "okay response");
        $display("test reset_unmapped done");
    endtask : t_reset
    task automatic t_sources();
        wr(`TSC_OFF_CTRL, RUN | SRC);
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        a = rd;
        repeat (100) @(posedge hclk);
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        span(rd - a, 32'h0000_0013, 32'h0000_0016, "internal steps");
        wr(`TSC_OFF_PRE_LO, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        rdc(`TSC_OFF_STAT, 32'h0000_0000, "zero preset not reached");
        check(rd & 32'h0000_0004, 32'h0000_0000, "zero preset is max");
        wr(`TSC_OFF_PRE_LO, 32'h0000_0003);
        repeat (3) @(posedge hclk);
        bus(1'b0, `TSC_OFF_STAT, 32'h0000_0000);
        check(rd & 32'h0000_0004, 32'h0000_0004, "small preset reached");
        wr(`TSC_OFF_CTRL, RUN | SRC | HLT);
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        b = rd;
        repeat (20) @(posedge hclk);
        rdc(`TSC_OFF_CNT_LO, b, "halted at preset");
        wr(`TSC_OFF_PRE_LO, 32'h0000_0000);
        wr(`TSC_OFF_CTRL, RUN);
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        a = rd;
        far.steps(7);
        repeat (4) @(posedge hclk);
        rdc(`TSC_OFF_CNT_LO, a + 32'h0000_0007, "external steps");
        $display("test sources done");
    endtask : t_sources
    task automatic t_reload();
        wr(`TSC_OFF_CTRL, RUN | SRC | RLD | POLH | OE);
        far.trigger(1'b1, 8);
        check({31'h0, aux1_oe}, 32'h0000_0000, "aux driver off");
        rdc(`TSC_OFF_CNT_LO, 32'h0000_0000, "held low word");
        rdc(`TSC_OFF_CNT_HI, 32'h0000_0000, "held high word");
        rdc(`TSC_OFF_STAT, 32'h0000_0002, "reload active");
        far.trigger(1'b0, 40);
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        span(rd, 32'h0000_0005, 32'h0000_000a, "free run after release");
        wr(`TSC_OFF_CTRL, RUN | SRC | RLD);
        repeat (8) @(posedge hclk);
        rdc(`TSC_OFF_CNT_LO, 32'h0000_0000, "low polarity holds");
        wr(`TSC_OFF_CTRL, RUN | SRC | OE);
        repeat (3) @(posedge hclk);
        check({31'h0, aux1_oe}, 32'h0000_0001, "aux driver on");
        check({31'h0, aux1_out}, 32'h0000_0001, "aux drives run state");
        $display("test reload done");
    endtask : t_reload
    task automatic t_capture();
        wr(`TSC_OFF_SEL, 32'h0000_0006);
        wr(`TSC_OFF_STAT, 32'h0000_0001);
        far.deadtime(16'h0001);
        bus(1'b0, `TSC_OFF_STAT, 32'h0000_0000);
        check(rd & 32'h0000_0001, 32'h0000_0000, "unselected busy");
        bus(1'b0, `TSC_OFF_CNT_LO, 32'h0000_0000);
        a = rd;
        far.deadtime(16'h0004);
        bus(1'b0, `TSC_OFF_CAP_LO, 32'h0000_0000);
        c = rd;
        span(c, a, a + 32'h0000_0002, "captured value");
        bus(1'b0, `TSC_OFF_STAT, 32'h0000_0000);
        check(rd & 32'h0000_0001, 32'h0000_0001, "capture flag");
        repeat (50) @(posedge hclk);
        rdc(`TSC_OFF_CAP_LO, c, "capture holds");
        far.deadtime(16'h0002);
        bus(1'b0, `TSC_OFF_CAP_LO, 32'h0000_0000);
        span(rd, c + 32'h0000_000a, c + 32'h0000_0014, "second line captures");
        $display("test capture done");
    endtask : t_capture
    task automatic t_stream();
        bus(1'b0, `TSC_OFF_CAP_LO, 32'h0000_0000);
        c = rd;
        bus(1'b0, `TSC_OFF_CAP_HI, 32'h0000_0000);
        ch = rd;
        wr(`TSC_OFF_CTRL, RUN | SRC | STMP);
        adc_data <= 32'hcafe_0001;
        adc_valid <= 1'b1;
        do @(posedge hclk); while (adc_ready !== 1'b1);
        adc_valid <= 1'b0;
        repeat (4) @(posedge hclk);
        // Output stalled: the stamp word must stand and input be refused
        check(out_data, c, "stalled stamp stands");
        check({31'h0, adc_ready}, 32'h0000_0000, "input refused");
        take(c, 1'b1);
        take(ch, 1'b1);
        take(32'hcafe_0001, 1'b0);
        out_ready <= 1'b0;
        // Without insertion the ADC word passes alone
        wr(`TSC_OFF_CTRL, RUN | SRC);
        adc_data <= 32'hcafe_0002;
        adc_valid <= 1'b1;
        do @(posedge hclk); while (adc_ready !== 1'b1);
        adc_valid <= 1'b0;
        take(32'hcafe_0002, 1'b0);
        out_ready <= 1'b0;
        $display("test stream done");
    endtask : t_stream
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, adc_valid, out_ready} = 4'h0;
        {haddr, hwdata, adc_data} = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_sources();
        t_reload();
        t_capture();
        t_stream();
        stop_test();
    end
endmodule : timestamp_counter_reload_capture_tb
`default_nettype wire
